/* src/dsep_pkg.sv */
// Constants and register map of the data separator input control.
// Function
// - Enable high routes read data, low write clock.
// - Every enable transition restarts clamp, and gain sequence when acquire high.
// - One to three period enable pulse is trigger.
// - Enable high reacts to read data rising edges.
// - Enable low reacts to write clock falling edges.
// - Coast low makes charge pump ignore pulses.
// - Divide select high halves clock, low passes.
// - Twice rate, undivided: add two-thirds rate clock.
// - Acquire low holds charge pump in low gain.
// - High gain on enable change, low after 37.
// - Read gate high phase mode, low frequency.
// - Filter mode high only phase and low gain.
// - Selected input synchronised at each enable edge, rising or falling.
package dsep_pkg;
  localparam logic [7:0]  CTRL_ADDR       = 8'h00;
  localparam logic [7:0]  STATUS_ADDR     = 8'h04;
  localparam int          CTL_ENABLE      = 0;
  localparam int          CTL_COAST_N     = 1;
  localparam int          CTL_DIVIDE      = 2;
  localparam int          CTL_ACQUIRE     = 3;
  localparam int          CTL_READ_GATE   = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h02;
  localparam int          ST_CLAMP        = 0;
  localparam int          ST_HIGH_GAIN    = 1;
  localparam int          ST_PHASE        = 2;
  localparam int          ST_FILTER       = 3;
  localparam int          ST_COUNT_LSB    = 8;
  localparam logic [5:0]  GAIN_PULSES     = 6'h25;
  localparam logic [2:0]  CLAMP_CYCLES    = 3'h4;
  localparam logic [1:0]  THIRD_LAST      = 2'h2;
  localparam logic [31:0] HRDATA_IDLE     = 32'h0000_0000;
  typedef enum logic {FREQ_MODE, PHASE_MODE} pd_mode_t;
endpackage

/* src/data_separator_input_control.sv */
// Input selector, restart sequencer, gain control and clock dividers.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module data_separator_input_control
  import dsep_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        readData,
  input  wire logic        writeClockIn,
  output logic             phaseRef,
  output logic             pumpPulse,
  output logic             oscClamp,
  output logic             highGain,
  output logic             filterMode,
  output logic             dataClock,
  output logic             twoThirdsClockOut
);
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0]  ctrl_r, ctrl_nxt;
  logic        pend_r, pend_nxt;
  logic        pendWr_r, pendWr_nxt;
  logic [7:0]  pendAddr_r, pendAddr_nxt;
  logic        ready_r, ready_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        enPrev_r, enPrev_nxt;
  logic        sel_r, sel_nxt;
  logic        rdPrev_r, rdPrev_nxt;
  logic        wcPrev_r, wcPrev_nxt;
  logic        pulse_r, pulse_nxt;
  logic        refOut_r, refOut_nxt;
  logic [2:0]  clampCnt_r, clampCnt_nxt;
  logic        gain_r, gain_nxt;
  logic [5:0]  gainCnt_r, gainCnt_nxt;
  pd_mode_t    mode_r, mode_nxt;
  logic        filt_r, filt_nxt;
  logic        half_r, half_nxt;
  logic        dclk_r, dclk_nxt;
  logic [1:0]  third_r, third_nxt;
  logic        tclk_r, tclk_nxt;
  logic        enable, coastN, divide, acquire, readGate;
  logic        toggle, edgeSeen, clampOn;

  assign enable   = ctrl_r[CTL_ENABLE];
  assign coastN   = ctrl_r[CTL_COAST_N];
  assign divide   = ctrl_r[CTL_DIVIDE];
  assign acquire  = ctrl_r[CTL_ACQUIRE];
  assign readGate = ctrl_r[CTL_READ_GATE];
  assign toggle   = enable != enPrev_r;
  assign clampOn  = clampCnt_r != 3'h0;
  // Only the edge kind of the routed channel counts as a pulse.
  assign edgeSeen = sel_r ? (readData & ~rdPrev_r)
                          : (~writeClockIn & wcPrev_r);

  ////////////////////////////////////////////////////////////////////////////
  // One wait state per transfer keeps hrdata straight from a flip-flop.
  always_comb
  begin
    pend_nxt     = 1'b0;
    pendWr_nxt   = pendWr_r;
    pendAddr_nxt = pendAddr_r;
    ready_nxt    = 1'b1;
    rdata_nxt    = rdata_r;
    ctrl_nxt     = ctrl_r;
    if (pend_r)
    begin
      if (pendWr_r && pendAddr_r == CTRL_ADDR)
        ctrl_nxt = hwdata[4:0];
      if (!pendWr_r && pendAddr_r == CTRL_ADDR)
        rdata_nxt = {27'h0000000, ctrl_r};
      else if (!pendWr_r && pendAddr_r == STATUS_ADDR)
        rdata_nxt = {18'h00000, gainCnt_r, 4'h0,
                     filt_r, mode_r == PHASE_MODE, gain_r, clampOn};
      else
        rdata_nxt = HRDATA_IDLE;
    end
    else if (hsel && htrans[1] && hready)
    begin
      pend_nxt     = 1'b1;
      pendWr_nxt   = hwrite;
      pendAddr_nxt = haddr[7:0];
      ready_nxt    = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    enPrev_nxt   = enable;
    // Channel choice is latched on each enable edge, so a one to three
    // cycle pulse still yields a clean restart with the inputs tied.
    sel_nxt      = toggle ? enable : sel_r;
    rdPrev_nxt   = readData;
    wcPrev_nxt   = writeClockIn;
    refOut_nxt   = sel_r ? readData : writeClockIn;
    pulse_nxt    = edgeSeen && coastN && !clampOn;
    clampCnt_nxt = toggle ? CLAMP_CYCLES
                 : (clampOn ? clampCnt_r - 3'h1 : clampCnt_r);
    gain_nxt     = gain_r;
    gainCnt_nxt  = gainCnt_r;
    if (!acquire)
    begin
      gain_nxt    = 1'b0;
      gainCnt_nxt = 6'h00;
    end
    else if (toggle)
    begin
      gain_nxt    = 1'b1;
      gainCnt_nxt = 6'h00;
    end
    else if (gain_r && edgeSeen)
    begin
      gainCnt_nxt = gainCnt_r + 6'h01;
      if (gainCnt_r == GAIN_PULSES - 6'h01)
        gain_nxt = 1'b0;
    end
    case (mode_r)
      FREQ_MODE:  mode_nxt = (readGate && !clampOn) ? PHASE_MODE : FREQ_MODE;
      PHASE_MODE: mode_nxt = readGate ? PHASE_MODE : FREQ_MODE;
      default:    mode_nxt = FREQ_MODE;
    endcase
    filt_nxt = mode_nxt == PHASE_MODE && !gain_nxt;
    // Dividers sit still while clamped and restart from phase zero.
    if (clampOn)
    begin
      half_nxt  = 1'b0;
      third_nxt = 2'h0;
      dclk_nxt  = 1'b0;
      tclk_nxt  = 1'b0;
    end
    else
    begin
      half_nxt  = ~half_r;
      third_nxt = (third_r == THIRD_LAST) ? 2'h0 : third_r + 2'h1;
      dclk_nxt  = divide ? ~half_r : 1'b1;
      tclk_nxt  = !divide && third_r == 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r     <= CTRL_RESET;
      pend_r     <= 1'b0;
      pendWr_r   <= 1'b0;
      pendAddr_r <= 8'h00;
      ready_r    <= 1'b1;
      rdata_r    <= HRDATA_IDLE;
      enPrev_r   <= 1'b0;
      sel_r      <= 1'b0;
      rdPrev_r   <= 1'b0;
      wcPrev_r   <= 1'b0;
      pulse_r    <= 1'b0;
      refOut_r   <= 1'b0;
      clampCnt_r <= 3'h0;
      gain_r     <= 1'b0;
      gainCnt_r  <= 6'h00;
      mode_r     <= FREQ_MODE;
      filt_r     <= 1'b0;
      half_r     <= 1'b0;
      dclk_r     <= 1'b0;
      third_r    <= 2'h0;
      tclk_r     <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      pend_r     <= pend_nxt;
      pendWr_r   <= pendWr_nxt;
      pendAddr_r <= pendAddr_nxt;
      ready_r    <= ready_nxt;
      rdata_r    <= rdata_nxt;
      enPrev_r   <= enPrev_nxt;
      sel_r      <= sel_nxt;
      rdPrev_r   <= rdPrev_nxt;
      wcPrev_r   <= wcPrev_nxt;
      pulse_r    <= pulse_nxt;
      refOut_r   <= refOut_nxt;
      clampCnt_r <= clampCnt_nxt;
      gain_r     <= gain_nxt;
      gainCnt_r  <= gainCnt_nxt;
      mode_r     <= mode_nxt;
      filt_r     <= filt_nxt;
      half_r     <= half_nxt;
      dclk_r     <= dclk_nxt;
      third_r    <= third_nxt;
      tclk_r     <= tclk_nxt;
    end
  end

  assign hrdata            = rdata_r;
  assign hreadyout         = ready_r;
  assign hresp             = 1'b0;
  assign phaseRef          = refOut_r;
  assign pumpPulse         = pulse_r;
  assign oscClamp          = clampOn;
  assign highGain          = gain_r;
  assign filterMode        = filt_r;
  assign dataClock         = dclk_r;
  assign twoThirdsClockOut = tclk_r;

  ////////////////////////////////////////////////////////////////////////////
  a_route_select: assert property (@(posedge clk) disable iff (!reset_n)
    !toggle |=> phaseRef == (sel_r ? $past(readData) : $past(writeClockIn)))
    else $error("phase reference not from selected input");
  a_toggle_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    toggle |=> oscClamp [*4])
    else $error("clamp length wrong after enable change");
  // A short enable pulse restarts the clamp, so release counts from the
  // last change only.
  a_clamp_end: assert property (@(posedge clk) disable iff (!reset_n)
    toggle ##1 !toggle [*4] |=> !oscClamp)
    else $error("clamp held past last enable change");
  a_short_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    toggle && acquire |=> highGain && gainCnt_r == 6'h00)
    else $error("enable change did not start high gain");
  a_rise_edge: assert property (@(posedge clk) disable iff (!reset_n)
    sel_r && $rose(readData) && coastN && !oscClamp |=> pumpPulse)
    else $error("read data rising edge missed");
  a_fall_edge: assert property (@(posedge clk) disable iff (!reset_n)
    !sel_r && $rose(writeClockIn) |=> !pumpPulse)
    else $error("write clock rising edge counted");
  a_coast_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !coastN |=> !pumpPulse)
    else $error("pulse passed while coasting");
  a_divide_two: assert property (@(posedge clk) disable iff (!reset_n)
    divide && !oscClamp && $past(divide) && $past(!oscClamp) && dataClock
    |=> !dataClock)
    else $error("divide by two not alternating");
  a_third_rate: assert property (@(posedge clk) disable iff (!reset_n)
    twoThirdsClockOut && !divide && !oscClamp |=> !twoThirdsClockOut)
    else $error("two thirds clock too fast");
  a_low_gain: assert property (@(posedge clk) disable iff (!reset_n)
    !acquire |=> !highGain)
    else $error("high gain while acquire low");
  a_gain_count: assert property (@(posedge clk) disable iff (!reset_n)
    highGain && acquire && !toggle && edgeSeen && gainCnt_r == 6'h24
    |=> !highGain)
    else $error("gain did not drop after count");
  a_read_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !readGate |=> mode_r == FREQ_MODE)
    else $error("phase mode with read gate low");
  a_filter_mode: assert property (@(posedge clk) disable iff (!reset_n)
    filterMode |-> mode_r == PHASE_MODE && !highGain)
    else $error("filter mode high outside phase low gain");
  a_div_restart: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(oscClamp) |-> third_r == 2'h0 && !half_r)
    else $error("dividers not restarted at clamp release");
endmodule // data_separator_input_control
`default_nettype wire

/* verification/drive_channel_model.sv */
// Behavioural drive channel: read data pulses and a write clock.
`timescale 1ns/100ps
`default_nettype none
module drive_channel_model
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic tieInputs,
  output logic      readData,
  output logic      writeClockIn
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  // Square wave at half the clock rate, equal high and low time.
  assign writeClockIn = cnt_r[0];
  // Tied mode stands in for an outside selector feeding both pins.
  assign readData = tieInputs ? cnt_r[0] : cnt_r[1];
endmodule // drive_channel_model
`default_nettype wire

/* verification/data_separator_input_control_tb.sv */
// Self-checking bench for the data separator input control.
`timescale 1ns/100ps
`default_nettype none
module data_separator_input_control_tb
  import dsep_pkg::*;
;
  logic        clk, reset_n, hsel, hwrite, tie, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        readData, writeClockIn, phaseRef, pumpPulse, oscClamp;
  logic        highGain, filterMode, dataClock, twoT;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          c;
  data_separator_input_control dut_u (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .readData(readData),
    .writeClockIn(writeClockIn), .phaseRef(phaseRef),
    .pumpPulse(pumpPulse), .oscClamp(oscClamp), .highGain(highGain),
    .filterMode(filterMode), .dataClock(dataClock),
    .twoThirdsClockOut(twoT));
  drive_channel_model part_u (.clk(clk), .reset_n(reset_n),
    .tieInputs(tie), .readData(readData), .writeClockIn(writeClockIn));
  ////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Back to back calls may skip the idle edge, for the shortest pulses.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input bit b2b = 1'b0);
    if (!b2b)
      @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask
  task automatic count(ref logic s, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k += int'(s === 1'b1);
    end
  endtask
  // History of the selected input, one sample per cycle.
  task automatic watch(input logic sel, cn);
    logic [2:0] v;
    v = 3'h0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk);
      if (i > 2)
      begin
        chk("phaseRef", {31'h0, v[0]}, phaseRef);
        chk("pumpPulse", {31'h0, cn & (sel ? v[0] & ~v[1] : ~v[0] & v[1])},
            pumpPulse);
      end
      v = {v[1:0], sel ? readData : writeClockIn};
    end
  endtask
  task automatic gain();
    int e;
    logic p;
    ahb(1'b1, CTRL_ADDR, 32'h0000_001B);
    @(negedge clk);
    chk("gainOn", 32'h0000_0001, highGain);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0012);
    @(negedge clk);
    chk("gainOff", 32'h0000_0000, highGain);
    ahb(1'b1, CTRL_ADDR, 32'h0000_001B);
    p = readData;
    @(negedge clk);
    chk("filterHg", 32'h0000_0000, filterMode);
    e = 0;
    while (highGain === 1'b1 && e < 99)
    begin
      e += int'(readData & ~p);
      p = readData;
      @(negedge clk);
    end
    chk("gainEdges", 32'h0000_0001, e >= 36 && e <= 38);
    repeat (2) @(negedge clk);
    chk("filterMode", 32'h0000_0001, filterMode);
    ahb(1'b0, STATUS_ADDR, 32'h0000_0000);
    chk("status", 32'h0000_000C, rd & 32'h0000_000F);
    chk("gainCount", {26'h0, GAIN_PULSES}, {26'h0, rd[13:8]});
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang is cut short well beyond the length of the whole run.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    {reset_n, hsel, hwrite, tie, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    ahb(1'b0, CTRL_ADDR, 32'h0000_0000);
    chk("ctrlReset", {27'h0, CTRL_RESET}, rd);
    ahb(1'b1, 8'h08, 32'h0000_001F);
    ahb(1'b0, 8'h08, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    ahb(1'b0, STATUS_ADDR, 32'h0000_0000);
    chk("statusReset", 32'h0000_0000, rd);
    watch(1'b0, 1'b1);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0003);
    count(oscClamp, 12, c);
    chk("clampRise", {29'h0, CLAMP_CYCLES}, c);
    watch(1'b1, 1'b1);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0001);
    watch(1'b1, 1'b0);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0000);
    count(oscClamp, 12, c);
    chk("clampFall", {29'h0, CLAMP_CYCLES}, c);
    @(posedge clk);
    tie <= 1'b1;
    ahb(1'b1, CTRL_ADDR, 32'h0000_0003);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0002, 1'b1);
    count(oscClamp, 12, c);
    chk("clampPulse", {29'h0, CLAMP_CYCLES}, c);
    watch(1'b0, 1'b1);
    @(posedge clk);
    tie <= 1'b0;
    ahb(1'b1, CTRL_ADDR, 32'h0000_0006);
    count(dataClock, 30, c);
    chk("divTwo", 32'h0000_000F, c);
    count(twoT, 30, c);
    chk("thirdsOff", 32'h0000_0000, c);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0002);
    count(dataClock, 30, c);
    chk("divOne", 32'h0000_001E, c);
    count(twoT, 30, c);
    chk("thirdsOn", 32'h0000_000A, c);
    gain();
    give_verdict();
  end
endmodule // data_separator_input_control_tb
`default_nettype wire
